// ===== rle_params.svh
// constants for the read latency and extended read parameter block
// What this block does
// - a nonzero latency field 1..15 gives exactly that many dummy cycles.
// - latency zero: single-lane fast read uses 8 in SPI, 6 in QPI.
// - latency zero: dual-output and quad-output fast reads use 8 dummy cycles.
// - latency zero: quad I/O reads use 6, dual I/O reads use 4.
// - unique-ID, parameter-table and info-row reads follow the fast read count.
// - dual I/O DDR read is refused while the link is in QPI mode.
// - bits 7..5 of the extended register set output driver strength.
// - bits 3..0 are read-only busy and error status, readable any time.
// - both extended set commands leave status bits 3..0 untouched.
// - bit 4 is reserved; writing it changes nothing.
// - opcode 85h writes the persistent copy, 83h the working copy.
// - persistent set touches only persistent copy; working set only working copy.
// - default reads drive strength and reserved bit as ones, status as zero.
// - working copies load from persistent copies before commands are accepted.
// - bit 0 mirrors the busy flag of the status register.
`ifndef RLE_PARAMS_SVH
`define RLE_PARAMS_SVH

// register set commands
`define RLE_OP_EXT_SET_NV   8'h85
`define RLE_OP_EXT_SET_V    8'h83
`define RLE_OP_RD_SET_NV    8'h65
`define RLE_OP_RD_SET_V0    8'hc0
`define RLE_OP_RD_SET_V1    8'h63

// read commands
`define RLE_OP_FAST_0       8'h0b
`define RLE_OP_FAST_1       8'h0c
`define RLE_OP_FAST_DDR_0   8'h0d
`define RLE_OP_FAST_DDR_1   8'h0e
`define RLE_OP_DOUT_0       8'h3b
`define RLE_OP_DOUT_1       8'h3c
`define RLE_OP_DIO_0        8'hbb
`define RLE_OP_DIO_1        8'hbc
`define RLE_OP_DIO_DDR_0    8'hbd
`define RLE_OP_DIO_DDR_1    8'hbe
`define RLE_OP_QOUT_0       8'h6b
`define RLE_OP_QOUT_1       8'h6c
`define RLE_OP_QIO_0        8'heb
`define RLE_OP_QIO_1        8'hec
`define RLE_OP_QIO_DDR_0    8'hed
`define RLE_OP_QIO_DDR_1    8'hee

// field positions
`define RLE_ODS_MSB         7
`define RLE_ODS_LSB         5
`define RLE_RSVD_BIT        4
`define RLE_EERR_BIT        3
`define RLE_PERR_BIT        2
`define RLE_PROT_BIT        1
`define RLE_BUSY_BIT        0
`define RLE_LAT_MSB         6
`define RLE_LAT_LSB         3

// reset values
`define RLE_EXT_RESET       8'hf0
`define RLE_RD_RESET        8'h00

// dummy counts with latency field zero
`define RLE_DUM_FAST_SPI    4'h8
`define RLE_DUM_FAST_QPI    4'h6
`define RLE_DUM_OUT         4'h8
`define RLE_DUM_QIO         4'h6
`define RLE_DUM_DIO         4'h4

// cycles spent copying persistent to working copies after reset
`define RLE_LOAD_CYCLES     4

`endif

// ===== rle_pkg.sv
// types for the read latency and extended read parameter block
package rle_pkg;

	typedef enum logic [1:0] {
		RLE_ST_LOAD = 2'b01,
		RLE_ST_RUN  = 2'b10
	} rle_state_t;

	typedef enum logic [2:0] {
		RLE_RC_NONE     = 3'h0,
		RLE_RC_FAST     = 3'h1,
		RLE_RC_OUT      = 3'h2,
		RLE_RC_DIO      = 3'h3,
		RLE_RC_DIO_DDR  = 3'h4,
		RLE_RC_QIO      = 3'h5
	} rle_rdcls_t;

endpackage : rle_pkg

// ===== rle_link_capture.sv
// link-clock capture of one command byte pair with a toggle event
`timescale 1ns/1ps
`default_nettype none

module rle_link_capture (
	// link clock and reset
	input  wire logic       lnk_sck,
	input  wire logic       lnk_rst,
	// decoded command from the framing logic
	input  wire logic       lnk_cmd_stb,
	input  wire logic [7:0] lnk_opcode,
	input  wire logic [7:0] lnk_data,
	input  wire logic       lnk_qpi,
	// held words and event toggle toward the system clock
	output logic      [7:0] cap_opcode_r,
	output logic      [7:0] cap_data_r,
	output logic            cap_qpi_r,
	output logic            cap_toggle_r
);

	// words stay put until the next strobe, so the far side may sample late
	always_ff @(posedge lnk_sck) begin
		if (lnk_rst) begin
			cap_opcode_r <= 8'h00;
			cap_data_r   <= 8'h00;
			cap_qpi_r    <= 1'b0;
		end else if (lnk_cmd_stb) begin
			cap_opcode_r <= lnk_opcode;
			cap_data_r   <= lnk_data;
			cap_qpi_r    <= lnk_qpi;
		end
	end

	always_ff @(posedge lnk_sck) begin
		if (lnk_rst) begin
			cap_toggle_r <= 1'b0;
		end else if (lnk_cmd_stb) begin
			cap_toggle_r <= ~cap_toggle_r;
		end
	end

endmodule : rle_link_capture

`default_nettype wire

// ===== rle_top.sv
// read latency selection and extended read parameter registers
`timescale 1ns/1ps
`default_nettype none
`include "rle_params.svh"

module rle_top #(
	parameter logic [7:0] OPC_UID  = 8'h4b,
	parameter logic [7:0] OPC_SFDP = 8'h5a,
	parameter logic [7:0] OPC_INFO_ROW_READ = 8'h68,
	parameter int         LOAD_CYC = `RLE_LOAD_CYCLES
) (
	// system clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// link side, on the serial clock
	input  wire logic       lnk_sck,
	input  wire logic       lnk_rst,
	input  wire logic       lnk_cmd_stb,
	input  wire logic [7:0] lnk_opcode,
	input  wire logic [7:0] lnk_data,
	input  wire logic       lnk_qpi,
	// status from the array controller, same clock
	input  wire logic       op_busy,
	input  wire logic       prot_err,
	input  wire logic       prog_err,
	input  wire logic       erase_err,
	// read setup results
	output logic      [3:0] dummy_cycles_r,
	output logic            dummy_valid_r,
	output logic            read_reject_r,
	output logic      [2:0] drive_strength_r,
	// register readback and readiness
	output logic      [7:0] ext_param_rd_r,
	output logic      [7:0] ext_param_nv_rd_r,
	output logic      [7:0] read_param_rd_r,
	output logic      [7:0] read_param_nv_rd_r,
	output logic            cmd_ready_r
);
	import rle_pkg::*;

	// named copy of the reset image so its fields can be sliced;
	// the reserved bit is taken from it and never from write data
	localparam logic [7:0] EXT_RST  = `RLE_EXT_RESET;
	localparam logic [2:0] ODS_RST  = EXT_RST[`RLE_ODS_MSB:`RLE_ODS_LSB];
	localparam logic       RSVD_VAL = EXT_RST[`RLE_RSVD_BIT];

	logic [7:0] cap_opcode;
	logic [7:0] cap_data;
	logic       cap_qpi;
	logic       cap_toggle;

	rle_link_capture u_cap (
		.lnk_sck      (lnk_sck),
		.lnk_rst      (lnk_rst),
		.lnk_cmd_stb  (lnk_cmd_stb),
		.lnk_opcode   (lnk_opcode),
		.lnk_data     (lnk_data),
		.lnk_qpi      (lnk_qpi),
		.cap_opcode_r (cap_opcode),
		.cap_data_r   (cap_data),
		.cap_qpi_r    (cap_qpi),
		.cap_toggle_r (cap_toggle)
	);

	// toggle synchroniser; only the second stage and later are looked at
	logic tog_s1_r;
	logic tog_s2_r;
	logic tog_s3_r;
	logic evt;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tog_s1_r <= 1'b0;
			tog_s2_r <= 1'b0;
			tog_s3_r <= 1'b0;
		end else begin
			tog_s1_r <= cap_toggle;
			tog_s2_r <= tog_s1_r;
			tog_s3_r <= tog_s2_r;
		end
	end

	assign evt = tog_s2_r ^ tog_s3_r;

	// the held words have been stable for at least one full mclk when evt fires
	logic [7:0] cmd_op_r;
	logic [7:0] cmd_data_r;
	logic       cmd_qpi_r;
	logic       cmd_pend_r;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cmd_op_r   <= 8'h00;
			cmd_data_r <= 8'h00;
			cmd_qpi_r  <= 1'b0;
		end else if (evt) begin
			cmd_op_r   <= cap_opcode;
			cmd_data_r <= cap_data;
			cmd_qpi_r  <= cap_qpi;
		end
	end

	// power-up sequencing
	rle_state_t state_r;
	rle_state_t state_nxt;
	logic [7:0] load_cnt_r;
	logic       load_done;

	assign load_done = (load_cnt_r == 8'(LOAD_CYC - 1));

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			RLE_ST_LOAD: begin
				if (load_done) begin
					state_nxt = RLE_ST_RUN;
				end
			end
			RLE_ST_RUN: begin
				state_nxt = RLE_ST_RUN;
			end
			default: begin
				state_nxt = RLE_ST_LOAD;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_r <= RLE_ST_LOAD;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			load_cnt_r <= 8'h00;
		end else if (state_r == RLE_ST_LOAD && !load_done) begin
			load_cnt_r <= load_cnt_r + 8'h01;
		end
	end

	// commands seen while loading are dropped, not queued
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cmd_pend_r <= 1'b0;
		end else begin
			cmd_pend_r <= evt && (state_r == RLE_ST_RUN);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			cmd_ready_r <= 1'b0;
		end else begin
			// follows the next state so it rises with the first cycle that accepts commands
			cmd_ready_r <= (state_nxt == RLE_ST_RUN);
		end
	end

	// command decode
	logic wr_ext_nv;
	logic wr_ext_v;
	logic wr_rd_nv;
	logic wr_rd_v;

	assign wr_ext_nv = cmd_pend_r && (cmd_op_r == `RLE_OP_EXT_SET_NV);
	assign wr_ext_v  = cmd_pend_r && (cmd_op_r == `RLE_OP_EXT_SET_V);
	assign wr_rd_nv  = cmd_pend_r && (cmd_op_r == `RLE_OP_RD_SET_NV);
	assign wr_rd_v   = cmd_pend_r && ((cmd_op_r == `RLE_OP_RD_SET_V0) ||
	                                  (cmd_op_r == `RLE_OP_RD_SET_V1));

	// persistent copies keep only the writable field; reset stands in for the
	// stored contents since no real non-volatile cell exists here
	logic [2:0] ext_ods_nv_r;
	logic [2:0] ext_ods_v_r;
	logic [7:0] rd_nv_r;
	logic [7:0] rd_v_r;

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ext_ods_nv_r <= ODS_RST;
		end else if (wr_ext_nv) begin
			ext_ods_nv_r <= cmd_data_r[`RLE_ODS_MSB:`RLE_ODS_LSB];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ext_ods_v_r <= ODS_RST;
		end else if (state_r == RLE_ST_LOAD) begin
			ext_ods_v_r <= ext_ods_nv_r;
		end else if (wr_ext_v) begin
			ext_ods_v_r <= cmd_data_r[`RLE_ODS_MSB:`RLE_ODS_LSB];
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rd_nv_r <= `RLE_RD_RESET;
		end else if (wr_rd_nv) begin
			rd_nv_r <= cmd_data_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rd_v_r <= `RLE_RD_RESET;
		end else if (state_r == RLE_ST_LOAD) begin
			rd_v_r <= rd_nv_r;
		end else if (wr_rd_v) begin
			rd_v_r <= cmd_data_r;
		end
	end

	// read command classification
	function automatic rle_rdcls_t classify(input logic [7:0] op);
		rle_rdcls_t c;
		c = RLE_RC_NONE;
		if (op == `RLE_OP_FAST_0 || op == `RLE_OP_FAST_1 ||
		    op == `RLE_OP_FAST_DDR_0 || op == `RLE_OP_FAST_DDR_1 ||
		    op == OPC_UID || op == OPC_SFDP || op == OPC_INFO_ROW_READ) begin
			c = RLE_RC_FAST;
		end else if (op == `RLE_OP_DOUT_0 || op == `RLE_OP_DOUT_1 ||
		             op == `RLE_OP_QOUT_0 || op == `RLE_OP_QOUT_1) begin
			c = RLE_RC_OUT;
		end else if (op == `RLE_OP_DIO_0 || op == `RLE_OP_DIO_1) begin
			c = RLE_RC_DIO;
		end else if (op == `RLE_OP_DIO_DDR_0 || op == `RLE_OP_DIO_DDR_1) begin
			c = RLE_RC_DIO_DDR;
		end else if (op == `RLE_OP_QIO_0 || op == `RLE_OP_QIO_1 ||
		             op == `RLE_OP_QIO_DDR_0 || op == `RLE_OP_QIO_DDR_1) begin
			c = RLE_RC_QIO;
		end
		return c;
	endfunction : classify

	// zero in the field picks a per-command default; anything else is literal
	function automatic logic [3:0] dummy_for(input rle_rdcls_t c,
	                                         input logic qpi,
	                                         input logic [3:0] lat);
		logic [3:0] d;
		d = lat;
		if (lat == 4'h0) begin
			case (c)
				RLE_RC_FAST:    d = qpi ? `RLE_DUM_FAST_QPI : `RLE_DUM_FAST_SPI;
				RLE_RC_OUT:     d = `RLE_DUM_OUT;
				RLE_RC_DIO:     d = `RLE_DUM_DIO;
				RLE_RC_DIO_DDR: d = `RLE_DUM_DIO;
				RLE_RC_QIO:     d = `RLE_DUM_QIO;
				default:        d = 4'h0;
			endcase
		end
		return d;
	endfunction : dummy_for

	rle_rdcls_t rd_cls;
	logic [3:0] lat_v;
	logic       is_read;
	logic       dio_ddr_qpi;

	assign rd_cls      = classify(cmd_op_r);
	assign lat_v       = rd_v_r[`RLE_LAT_MSB:`RLE_LAT_LSB];
	assign is_read     = cmd_pend_r && (rd_cls != RLE_RC_NONE);
	assign dio_ddr_qpi = (rd_cls == RLE_RC_DIO_DDR) && cmd_qpi_r;

	// only the dual I/O DDR read is refused in QPI; other reads still get a count
	// count holds between reads so the data path may sample it at leisure
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dummy_cycles_r <= 4'h0;
		end else if (is_read && !dio_ddr_qpi) begin
			dummy_cycles_r <= dummy_for(rd_cls, cmd_qpi_r, lat_v);
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			dummy_valid_r <= 1'b0;
		end else begin
			dummy_valid_r <= is_read && !dio_ddr_qpi;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			read_reject_r <= 1'b0;
		end else begin
			read_reject_r <= is_read && dio_ddr_qpi;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			drive_strength_r <= ODS_RST;
		end else begin
			drive_strength_r <= ext_ods_v_r;
		end
	end

	// readback; status bits are never stored from writes, only sampled live
	// live mirrors, not sticky: the array controller owns setting and clearing
	logic [3:0] status_now;

	assign status_now = {erase_err, prog_err, prot_err, op_busy};

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ext_param_rd_r <= `RLE_EXT_RESET;
		end else begin
			ext_param_rd_r <= {ext_ods_v_r, RSVD_VAL, status_now};
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ext_param_nv_rd_r <= `RLE_EXT_RESET;
		end else begin
			ext_param_nv_rd_r <= {ext_ods_nv_r, RSVD_VAL, status_now};
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			read_param_rd_r <= `RLE_RD_RESET;
		end else begin
			read_param_rd_r <= rd_v_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			read_param_nv_rd_r <= `RLE_RD_RESET;
		end else begin
			read_param_nv_rd_r <= rd_nv_r;
		end
	end

endmodule : rle_top

`default_nettype wire

// ===== rle_top_checker.sv
// concurrent checks on the ports of the read latency block
`timescale 1ns/1ps
`default_nettype none

module rle_top_checker #(
	parameter int LOAD_CYC = 4
) (
	input wire logic       mclk,
	input wire logic       sys_rst,
	input wire logic       op_busy,
	input wire logic       prot_err,
	input wire logic       prog_err,
	input wire logic       erase_err,
	input wire logic [3:0] dummy_cycles_r,
	input wire logic       dummy_valid_r,
	input wire logic       read_reject_r,
	input wire logic [2:0] drive_strength_r,
	input wire logic [7:0] ext_param_rd_r,
	input wire logic [7:0] ext_param_nv_rd_r,
	input wire logic [7:0] read_param_rd_r,
	input wire logic       cmd_ready_r
);
	localparam int RDY_LO = LOAD_CYC - 1;
	localparam int RDY_HI = LOAD_CYC + 1;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);

	property p_valid_pulse;
		dummy_valid_r |=> !dummy_valid_r;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("read pulse too long");
	property p_lat_map;
		dummy_valid_r && read_param_rd_r[6:3] != 4'h0 |-> dummy_cycles_r == read_param_rd_r[6:3];
	endproperty
	a_lat_map: assert property (p_lat_map) else $error("latency not applied");
	property p_reject_keep;
		read_reject_r |-> !dummy_valid_r && $stable(dummy_cycles_r);
	endproperty
	a_reject_keep: assert property (p_reject_keep) else $error("refused read moved count");
	property p_dummy_hold;
		!dummy_valid_r && !$past(sys_rst) |-> $stable(dummy_cycles_r);
	endproperty
	a_dummy_hold: assert property (p_dummy_hold) else $error("count moved without read");
	property p_status;
		!$past(sys_rst) |-> ext_param_rd_r[3:0] == $past({erase_err, prog_err, prot_err, op_busy});
	endproperty
	a_status: assert property (p_status) else $error("status bits wrong");
	property p_nv_status;
		!$past(sys_rst) |-> ext_param_nv_rd_r[3:0] == $past({erase_err, prog_err, prot_err, op_busy});
	endproperty
	a_nv_status: assert property (p_nv_status) else $error("persistent status wrong");
	property p_rsvd;
		ext_param_rd_r[4] && ext_param_nv_rd_r[4];
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit not one");
	property p_drive;
		!$past(sys_rst) |-> drive_strength_r == ext_param_rd_r[7:5];
	endproperty
	a_drive: assert property (p_drive) else $error("drive strength not from working copy");
	property p_ready;
		$fell(sys_rst) |-> !cmd_ready_r ##[RDY_LO:RDY_HI] cmd_ready_r;
	endproperty
	a_ready: assert property (p_ready) else $error("load time wrong");
	property p_ready_keep;
		cmd_ready_r |=> cmd_ready_r;
	endproperty
	a_ready_keep: assert property (p_ready_keep) else $error("ready dropped");
	property p_no_early;
		!cmd_ready_r |-> !dummy_valid_r && !read_reject_r;
	endproperty
	a_no_early: assert property (p_no_early) else $error("command before load");
endmodule : rle_top_checker

bind rle_top rle_top_checker #(.LOAD_CYC(LOAD_CYC)) i_rle_top_checker (
	.mclk(mclk), .sys_rst(sys_rst), .op_busy(op_busy), .prot_err(prot_err),
	.prog_err(prog_err), .erase_err(erase_err), .dummy_cycles_r(dummy_cycles_r),
	.dummy_valid_r(dummy_valid_r), .read_reject_r(read_reject_r),
	.drive_strength_r(drive_strength_r), .ext_param_rd_r(ext_param_rd_r),
	.ext_param_nv_rd_r(ext_param_nv_rd_r), .read_param_rd_r(read_param_rd_r),
	.cmd_ready_r(cmd_ready_r));

`default_nettype wire

// ===== rle_host_model.sv
// host controller model issuing decoded commands on the link clock
`timescale 1ns/1ps
`default_nettype none

module rle_host_model (
	// link toward the block
	output logic       lnk_sck,
	output logic       lnk_rst,
	output logic       lnk_cmd_stb,
	output logic [7:0] lnk_opcode,
	output logic [7:0] lnk_data,
	output logic       lnk_qpi
);
	initial begin
		lnk_sck = 1'b0;
		lnk_rst = 1'b0;
		lnk_cmd_stb = 1'b0;
		lnk_opcode = 8'h00;
		lnk_data = 8'h00;
		lnk_qpi = 1'b0;
	end

	// the serial clock only runs inside a frame
	task automatic tick(input int n);
		repeat (n) begin
			#6 lnk_sck = 1'b1;
			#6 lnk_sck = 1'b0;
		end
	endtask : tick

	task automatic link_reset();
		lnk_rst = 1'b1;
		tick(3);
		lnk_rst = 1'b0;
		tick(2);
	endtask : link_reset

	task automatic send(input logic [7:0] op, input logic [7:0] d, input logic q);
		lnk_cmd_stb = 1'b1;
		lnk_opcode = op;
		lnk_data = d;
		lnk_qpi = q;
		tick(1);
		// released lines show the inverse so stale values cannot pass as valid
		lnk_cmd_stb = 1'b0;
		lnk_opcode = ~op;
		lnk_data = ~d;
		lnk_qpi = ~q;
		// trailing cycles keep strobes over 200 ns apart; rate is well below limits
		tick(19);
	endtask : send
endmodule : rle_host_model

`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the read latency and extended parameter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
	$display("Error at %0t: got %0h expected %0h", $time, (a), (e)); end end

module tb_top;
	logic       mclk = 1'b0;
	logic       sys_rst = 1'b1;
	logic [3:0] stat = 4'h0;
	logic       lnk_sck, lnk_rst, lnk_cmd_stb, lnk_qpi, dvalid, reject, ready;
	logic [7:0] lnk_opcode, lnk_data, ext_rd, ext_nv_rd, rd_rd, rd_nv_rd;
	logic [3:0] dummy;
	logic [2:0] drive;
	int         num_errors = 0;
	int         num_checks = 0;

	always #12.5 mclk = ~mclk;

	rle_host_model i_rle_host_model (.lnk_sck(lnk_sck), .lnk_rst(lnk_rst),
		.lnk_cmd_stb(lnk_cmd_stb), .lnk_opcode(lnk_opcode), .lnk_data(lnk_data),
		.lnk_qpi(lnk_qpi));
	rle_top i_rle_top (.mclk(mclk), .sys_rst(sys_rst), .lnk_sck(lnk_sck), .lnk_rst(lnk_rst),
		.lnk_cmd_stb(lnk_cmd_stb), .lnk_opcode(lnk_opcode), .lnk_data(lnk_data),
		.lnk_qpi(lnk_qpi), .op_busy(stat[0]), .prot_err(stat[1]), .prog_err(stat[2]),
		.erase_err(stat[3]), .dummy_cycles_r(dummy), .dummy_valid_r(dvalid),
		.read_reject_r(reject), .drive_strength_r(drive), .ext_param_rd_r(ext_rd),
		.ext_param_nv_rd_r(ext_nv_rd), .read_param_rd_r(rd_rd),
		.read_param_nv_rd_r(rd_nv_rd), .cmd_ready_r(ready));

	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : finish_test

	task automatic clk_wait(input int n);
		repeat (n) @(posedge mclk);
		#2;
	endtask : clk_wait

	task automatic set_stat(input logic [3:0] s);
		clk_wait(1);
		stat = s;
		clk_wait(2);
	endtask : set_stat

	task automatic cmd(input logic [7:0] op, input logic [7:0] d, input logic q);
		i_rle_host_model.send(op, d, q);
		clk_wait(2);
	endtask : cmd

	// the pulse lasts one cycle, so it is caught while the command is still in flight
	task automatic send_wait(input logic [7:0] op, input logic q, output logic r,
		output logic [3:0] d);
		int i;
		fork
			i_rle_host_model.send(op, 8'h00, q);
			begin
				for (i = 0; i < 40 && dvalid !== 1'b1 && reject !== 1'b1; i++) begin
					@(posedge mclk);
					#1;
				end
				r = reject;
				d = dummy;
			end
		join
		if (i == 40) begin
			num_errors++;
			finish_test();
		end
	endtask : send_wait

	task automatic rd(input logic [7:0] op, input logic q, input logic [3:0] exp);
		logic       r;
		logic [3:0] d;
		send_wait(op, q, r, d);
		`CHK(r, 1'b0)
		`CHK(d, exp)
	endtask : rd

	task automatic t_reset();
		fork
			i_rle_host_model.link_reset();
			clk_wait(4);
		join
		sys_rst = 1'b0;
		for (int i = 0; i < 20 && ready !== 1'b1; i++)
			clk_wait(1);
		`CHK(ready, 1'b1)
		if (ready !== 1'b1)
			finish_test();
		`CHK(ext_rd, 8'hf0)
		`CHK(ext_nv_rd, 8'hf0)
		`CHK(drive, 3'h7)
		`CHK(rd_rd, 8'h00)
	endtask : t_reset

	task automatic t_status();
		for (int k = 0; k < 4; k++) begin
			set_stat(4'h1 << k);
			`CHK(ext_rd[3:0], 4'h1 << k)
			`CHK(ext_nv_rd[3:0], 4'h1 << k)
		end
	endtask : t_status

	task automatic t_ext();
		set_stat(4'h5);
		cmd(8'h83, 8'h1f, 1'b0);
		`CHK(ext_rd, 8'h15)
		`CHK(drive, 3'h0)
		`CHK(ext_nv_rd, 8'hf5)
		cmd(8'h85, 8'h4a, 1'b1);
		`CHK(ext_nv_rd, 8'h55)
		`CHK(ext_rd, 8'h15)
		cmd(8'h83, 8'hc0, 1'b0);
		`CHK(drive, 3'h6)
		set_stat(4'h0);
	endtask : t_ext

	// entries are opcode, qpi flag, expected count
	task automatic t_defaults();
		logic [15:0] tbl [19] = '{16'h0b08, 16'h0c16, 16'h0d08, 16'h0e16, 16'h4b08, 16'h5a16,
			16'h6808, 16'h3b08, 16'h3c08, 16'h6b08, 16'h6c08, 16'hbb04, 16'hbc04, 16'hbd04,
			16'hbe04, 16'heb06, 16'hec16, 16'hed06, 16'hee16};
		for (int i = 0; i < 19; i++)
			rd(tbl[i][15:8], tbl[i][4], tbl[i][3:0]);
	endtask : t_defaults

	task automatic t_reject();
		logic       r;
		logic [3:0] d;
		for (int i = 0; i < 2; i++) begin
			rd(8'h0c, 1'b1, 4'h6);
			send_wait(8'hbd + 8'(i), 1'b1, r, d);
			`CHK(r, 1'b1)
			`CHK(d, 4'h6)
		end
	endtask : t_reject

	task automatic t_lat();
		logic [7:0] vals [3] = '{8'h08, 8'h28, 8'h78};
		for (int i = 0; i < 3; i++) begin
			cmd((i == 1) ? 8'h63 : 8'hc0, vals[i], 1'b0);
			`CHK(rd_rd, vals[i])
			rd(8'hed, 1'b1, vals[i][6:3]);
			rd(8'h3b, 1'b0, vals[i][6:3]);
		end
		cmd(8'h65, 8'h48, 1'b0);
		`CHK(rd_nv_rd, 8'h48)
		`CHK(rd_rd, 8'h78)
		rd(8'h4b, 1'b0, 4'hf);
	endtask : t_lat

	initial begin
		t_reset();
		t_status();
		t_ext();
		t_defaults();
		t_reject();
		t_lat();
		finish_test();
	end
endmodule : tb_top

`default_nettype wire
